/* lcdw_chk.sv */
// Purpose: port checks of lcdw_ctrl
// Assumes: one clock domain, synchronous reset
// Notes:   bound to every lcdw_ctrl instance
`timescale 1ns/10ps
module lcdw_chk (
  input logic        mclk,
  input logic        sys_rst,
  input logic        reg_rd,
  input logic [7:0]  reg_rdata,
  input logic [63:0] pad_level,
  input logic [31:0] pad_lcd_en,
  input logic        waveform_active,
  input logic        frame_start,
  input logic        pump_strobe,
  input logic        bias_gen_run,
  input logic        bias_gen_discharge,
  input logic        bias_ratio_half,
  input logic        internal_ref_sel
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic grp_ok;
  // a group of four pins never splits between lcd and port use
  always_comb begin
    grp_ok = 1'b1;
    for (int g = 0; g < 8; g++)
      if (pad_lcd_en[4*g+:4] != 4'h0 && pad_lcd_en[4*g+:4] != 4'hf) grp_ok = 1'b0;
  end
  a_lcd_en_group: assert property (grp_ok)
    else $error("pin enables split inside a group");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_sleep_pads: assert property (!waveform_active [*2] |-> pad_level == 64'h0)
    else $error("pads not at V0 while stopped");
  a_frame_active: assert property (frame_start |=> waveform_active)
    else $error("frame start while stopped");
  a_frame_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  a_pump_run: assert property (pump_strobe |-> bias_gen_run)
    else $error("pump strobe with generator halted");
  a_pump_pulse: assert property (pump_strobe |=> !pump_strobe)
    else $error("pump strobe longer than one cycle");
  a_off_forces: assert property (bias_gen_discharge |->
    !bias_gen_run && !bias_ratio_half && !internal_ref_sel)
    else $error("generator bits active while off");
  c_frame: cover property (frame_start);
  c_sleep: cover property ($fell(waveform_active));
  c_pump: cover property (pump_strobe);
endmodule // lcdw_chk

bind lcdw_ctrl lcdw_chk lcdw_chk_inst (.mclk, .sys_rst, .reg_rd, .reg_rdata, .pad_level,
  .pad_lcd_en, .waveform_active, .frame_start, .pump_strobe, .bias_gen_run,
  .bias_gen_discharge, .bias_ratio_half, .internal_ref_sel);

/* lcdw_ctrl.v */
// Purpose: segment lcd waveform controller (lcd mode), frame timing and bias control bits
// Assumes: src_tick and pump_tick are one-cycle pulses from the clock block
// Notes:   pad levels are 2-bit codes selecting rail V0..V3; analog is outside
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "lcdw_defs.vh"

module lcdw_ctrl (
  input  wire                     mclk,
  input  wire                     sys_rst,
  input  wire                     clk_en,
  input  wire [`LCDW_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [7:0]               reg_rdata,
  input  wire [3:0]               src_tick,
  input  wire [3:0]               pump_tick,
  input  wire [31:0]              port_pin_in,
  output reg  [63:0]              pad_level,
  output reg  [31:0]              pad_lcd_en,
  output reg  [1:0]               common_pin_zero,
  output reg  [1:0]               common_pin_one,
  output reg                      waveform_active,
  output reg                      frame_start,
  output reg                      pump_strobe,
  output reg                      bias_gen_run,
  output reg                      bias_gen_discharge,
  output reg                      bias_ratio_half,
  output reg                      internal_ref_sel
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // nibble mask of used bits for a mux code
  function [3:0] nib_mask;
    input [1:0] mux;
    begin
      case (mux)
        `LCDW_MUX_DD: nib_mask = 4'h1;
        `LCDW_MUX_2:  nib_mask = 4'h3;
        `LCDW_MUX_3:  nib_mask = 4'h7;
        default:      nib_mask = 4'hf;
      endcase
    end
  endfunction

  // byte mask of a data register; register 15 loses pads used as commons
  function [7:0] reg_mask;
    input [1:0] mux;
    input [3:0] idx;
    begin
      reg_mask = {nib_mask(mux), nib_mask(mux)};
      if (idx == `LCDW_LAST_REG && mux == `LCDW_MUX_3)
        reg_mask = {4'h0, nib_mask(mux)};
      if (idx == `LCDW_LAST_REG && mux == `LCDW_MUX_4)
        reg_mask = 8'h00;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] seg_pend_r [0:15];
  reg [7:0] seg_act_r  [0:15];
  reg [7:0] port_pull_r [0:3];
  reg [7:0] port_dir_r  [0:3];
  reg [7:0] port_out_r  [0:3];
  reg [7:0] pin_function_select_reg;
  reg [7:0] driver_control_reg;
  reg [7:0] frame_clock_reg;
  reg [7:0] bias_gen_config_reg;
  reg [2:0] div_cnt_r;
  reg [2:0] phase_r;
  reg       running_r;
  reg [7:0] rdata_nxt;
  integer   i;
  integer   p;
  integer   q;

  wire [1:0] mux_scheme_sel  = driver_control_reg[`LCDW_CTRL_MUX];
  wire       waveform_sleep  = driver_control_reg[`LCDW_CTRL_SLEEP];
  wire [1:0] source_freq_sel = frame_clock_reg[`LCDW_FR_FREQ];
  wire [2:0] frame_div_sel   = frame_clock_reg[`LCDW_FR_DIV];
  wire       bias_gen_shutdown = bias_gen_config_reg[`LCDW_BG_OFF];
  wire       bias_gen_standby  = bias_gen_config_reg[`LCDW_BG_STDB];
  wire       lcd_mode  = (pin_function_select_reg == `LCDW_ALL_LCD);
  wire       port_wr_ok = reg_wr & ~lcd_mode;
  wire [3:0] reg_idx   = reg_addr[3:0];
  wire [1:0] port_idx  = reg_addr[1:0];

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  // one phase per (div+1) source ticks; two phases per common for dc balance
  wire       src_sel   = src_tick[source_freq_sel];
  wire       phase_tk  = src_sel & (div_cnt_r == frame_div_sel);
  wire [2:0] last_ph   = {mux_scheme_sel, 1'b1};
  wire       frame_end = running_r & phase_tk & (phase_r == last_ph);
  // start from stop: sleep cleared, resume on the next phase boundary
  wire       restart   = ~running_r & ~waveform_sleep & phase_tk;
  wire       load_act  = frame_end | restart;

  always @(posedge mclk) begin
    if (sys_rst) begin
      div_cnt_r <= 3'h0;
      phase_r   <= 3'h0;
      running_r <= 1'b0;
    end else if (clk_en) begin
      if (src_sel)
        div_cnt_r <= phase_tk ? 3'h0 : div_cnt_r + 3'h1;
      if (frame_end) begin
        phase_r   <= 3'h0;
        running_r <= ~waveform_sleep;
      end else if (restart) begin
        phase_r   <= 3'h0;
        running_r <= 1'b1;
      end else if (running_r && phase_tk) begin
        phase_r   <= phase_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      pin_function_select_reg <= `LCDW_SEL_RST;
      driver_control_reg      <= `LCDW_CTRL_RST;
      frame_clock_reg         <= `LCDW_FRAME_RST;
      bias_gen_config_reg     <= `LCDW_BIAS_RST;
      for (i = 0; i < 16; i = i + 1) begin
        seg_pend_r[i] <= 8'h00;
        seg_act_r[i]  <= 8'h00;
      end
      for (i = 0; i < 4; i = i + 1) begin
        port_pull_r[i] <= 8'h00;
        port_dir_r[i]  <= 8'h00;
        port_out_r[i]  <= 8'h00;
      end
    end else if (clk_en) begin
      // pending copy accepted in any state, sleep included
      if (reg_wr && reg_addr <= `LCDW_SEG_LAST)
        seg_pend_r[reg_idx] <= reg_wdata;
      if (reg_wr && reg_addr == `LCDW_SEL_ADDR)
        pin_function_select_reg <= reg_wdata;
      if (reg_wr && reg_addr == `LCDW_CTRL_ADDR)
        driver_control_reg <= reg_wdata;
      if (reg_wr && reg_addr == `LCDW_FRAME_ADDR)
        frame_clock_reg <= reg_wdata;
      if (reg_wr && reg_addr == `LCDW_BIAS_ADDR)
        bias_gen_config_reg <= reg_wdata;
      if (port_wr_ok && reg_addr[5:2] == `LCDW_PULL_BASE >> 2)
        port_pull_r[port_idx] <= reg_wdata;
      if (port_wr_ok && reg_addr[5:2] == `LCDW_DIR_BASE >> 2)
        port_dir_r[port_idx] <= reg_wdata;
      if (port_wr_ok && reg_addr[5:2] == `LCDW_OUT_BASE >> 2)
        port_out_r[port_idx] <= reg_wdata;
      // a write in the load cycle is not lost: it lands in the active copy too
      if (load_act) begin
        for (i = 0; i < 16; i = i + 1)
          seg_act_r[i] <= (reg_wr && reg_addr == i) ? reg_wdata : seg_pend_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_addr <= `LCDW_SEG_LAST)
      rdata_nxt = seg_act_r[reg_idx] & reg_mask(mux_scheme_sel, reg_idx);
    else if (reg_addr == `LCDW_SEL_ADDR)
      rdata_nxt = pin_function_select_reg;
    else if (reg_addr == `LCDW_CTRL_ADDR)
      rdata_nxt = {5'h00, driver_control_reg[2:0]};
    else if (reg_addr == `LCDW_FRAME_ADDR)
      rdata_nxt = {frame_clock_reg[7:5], 3'h0, frame_clock_reg[1:0]};
    else if (reg_addr == `LCDW_BIAS_ADDR)
      rdata_nxt = {2'h0, bias_gen_config_reg[5:0]};
    else if (!lcd_mode && reg_addr[5:2] == `LCDW_PULL_BASE >> 2)
      rdata_nxt = port_pull_r[port_idx];
    else if (!lcd_mode && reg_addr[5:2] == `LCDW_DIR_BASE >> 2)
      rdata_nxt = port_dir_r[port_idx];
    else if (!lcd_mode && reg_addr[5:2] == `LCDW_OUT_BASE >> 2)
      rdata_nxt = port_out_r[port_idx];
    else if (!lcd_mode && reg_addr >= `LCDW_IN_BASE && reg_addr <= `LCDW_IN_LAST)
      rdata_nxt = port_pin_in[port_idx*8 +: 8];
  end

  always @(posedge mclk) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // waveform levels
  // ----------------------------------------------------------------
  // phase_r[0] is polarity, phase_r[2:1] the active common
  reg  [1:0] sel_com;
  reg  [1:0] nsel_com;
  reg  [1:0] seg_on;
  reg  [1:0] seg_off;
  reg  [63:0] level_nxt;
  reg  [3:0]  nib;
  reg  [1:0]  com_idx;
  reg         pol;
  reg         is_com;

  always @* begin
    pol      = phase_r[0];
    com_idx  = phase_r[2:1];
    sel_com  = pol ? `LCDW_V0 : `LCDW_V3;
    seg_on   = pol ? `LCDW_V3 : `LCDW_V0;
    // direct drive has no middle rails; 1:2 uses V2 only as its middle
    case (mux_scheme_sel)
      `LCDW_MUX_DD: begin
        nsel_com = sel_com;
        seg_off  = sel_com;
      end
      `LCDW_MUX_2: begin
        nsel_com = `LCDW_V2;
        seg_off  = `LCDW_V2;
      end
      default: begin
        nsel_com = pol ? `LCDW_V2 : `LCDW_V1;
        seg_off  = pol ? `LCDW_V1 : `LCDW_V2;
      end
    endcase
    level_nxt = 64'h0;
    nib       = 4'h0;
    is_com    = 1'b0;
    for (p = 0; p < 32; p = p + 1) begin
      nib    = p[0] ? seg_act_r[p >> 1][7:4] : seg_act_r[p >> 1][3:0];
      nib    = nib & nib_mask(mux_scheme_sel);
      is_com = (p == 31 && mux_scheme_sel >= `LCDW_MUX_3) ||
               (p == 30 && mux_scheme_sel == `LCDW_MUX_4);
      if (!running_r)
        level_nxt[p*2 +: 2] = `LCDW_V0;
      else if (is_com)
        level_nxt[p*2 +: 2] = (com_idx == ((p == 31) ? 2'h2 : 2'h3)) ?
                              sel_com : nsel_com;
      else
        level_nxt[p*2 +: 2] = nib[com_idx] ? seg_on : seg_off;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      pad_level          <= 64'h0;
      pad_lcd_en         <= 32'h0;
      common_pin_zero    <= `LCDW_V0;
      common_pin_one     <= `LCDW_V0;
      waveform_active    <= 1'b0;
      frame_start        <= 1'b0;
      pump_strobe        <= 1'b0;
      bias_gen_run       <= 1'b0;
      bias_gen_discharge <= 1'b0;
      bias_ratio_half    <= 1'b0;
      internal_ref_sel   <= 1'b0;
    end else if (clk_en) begin
      pad_level <= level_nxt;
      for (q = 0; q < 8; q = q + 1)
        pad_lcd_en[q*4 +: 4] <= {4{pin_function_select_reg[q]}};
      common_pin_zero <= !running_r ? `LCDW_V0 :
                         (com_idx == 2'h0) ? sel_com : nsel_com;
      common_pin_one  <= (!running_r || mux_scheme_sel == `LCDW_MUX_DD) ? `LCDW_V0 :
                         (com_idx == 2'h1) ? sel_com : nsel_com;
      waveform_active <= running_r;
      // a frame that ends into sleep starts nothing, so no pulse then
      frame_start     <= (frame_end & ~waveform_sleep) | restart;
      bias_gen_run    <= ~bias_gen_shutdown & ~bias_gen_standby;
      // standby clears bias_gen_run and blocks the pump strobe, rails are not discharged
      pump_strobe     <= pump_tick[bias_gen_config_reg[`LCDW_BG_CLK]] &
                         ~bias_gen_shutdown & ~bias_gen_standby;
      bias_gen_discharge <= bias_gen_shutdown;
      bias_ratio_half  <= bias_gen_config_reg[`LCDW_BG_MODE] & ~bias_gen_shutdown;
      internal_ref_sel <= bias_gen_config_reg[`LCDW_BG_REF] & ~bias_gen_shutdown;
    end
  end

endmodule // lcdw_ctrl

/* lcdw_ctrl_tb_top.sv */
// Purpose: self-checking bench of lcdw_ctrl
// Assumes: ticks compressed, source and pump bit k every 64>>k cycles
// Notes:   expected periods follow from that spacing
`timescale 1ns/10ps
`include "lcdw_defs.vh"
module lcdw_ctrl_tb_top;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  tick = 4'h0;
  logic [5:0]  tcnt = 6'h00;
  logic [31:0] pins = 32'ha5c30f96;
  logic [7:0]  reg_rdata;
  logic [63:0] pad_level;
  logic [31:0] pad_lcd_en;
  logic [1:0]  com0, com1, lit;
  logic        active, fstart, pump, run, dis, half, iref;
  logic        gclr = 1'b1;
  logic        cen = 1'b1;
  int          err_total = 0;
  int          samples_checked = 0;
  // ------
  // harness
  // ------
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    tcnt <= tcnt + 6'h01;
    for (int k = 0; k < 4; k++)
      tick[k] <= ((tcnt & (6'h3f >> k)) == 6'h00);
  end
  lcdw_ctrl lcdw_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .clk_en(cen),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_tick(tick), .pump_tick(tick), .port_pin_in(pins),
    .pad_level(pad_level), .pad_lcd_en(pad_lcd_en), .common_pin_zero(com0),
    .common_pin_one(com1), .waveform_active(active), .frame_start(fstart),
    .pump_strobe(pump), .bias_gen_run(run), .bias_gen_discharge(dis),
    .bias_ratio_half(half), .internal_ref_sel(iref));
  lcdw_glass lcdw_glass_inst (.mclk(mclk), .clr(gclr), .seg_lvl(pad_level[1:0]),
    .com0_lvl(com0), .com1_lvl(com1), .lit(lit));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {56'h0, e}, {56'h0, reg_rdata});
  endtask
  task automatic wfs(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (fstart !== 1'b1 && n < 9000);
    if (n >= 9000) chk("frame wait", 64'h0, 64'h1);
  endtask
  task automatic outs(input string what, input logic [3:0] e);
    repeat (3) @(posedge mclk);
    chk(what, {60'h0, e}, {60'h0, run, dis, half, iref});
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    rchk(`LCDW_BIAS_ADDR, 8'h28);
    chk("reset outs", 64'h4, {60'h0, run, dis, half, iref});
    wr(`LCDW_PULL_BASE, 8'h5a);
    rchk(`LCDW_PULL_BASE, 8'h5a);
    rchk(`LCDW_IN_BASE, pins[7:0]);
    wr(`LCDW_SEL_ADDR, 8'h0f);
    repeat (3) @(posedge mclk);
    chk("lcd_en", 64'h0000ffff, {32'h0, pad_lcd_en});
    wr(`LCDW_SEL_ADDR, `LCDW_ALL_LCD);
    wr(`LCDW_PULL_BASE, 8'h33);
    repeat (3) @(posedge mclk);
    chk("lcd_en", 64'hffffffff, {32'h0, pad_lcd_en});
    rchk(`LCDW_PULL_BASE, 8'h00);
    rchk(`LCDW_IN_BASE, 8'h00);
    rchk(6'h3f, 8'h00);
    wr(`LCDW_SEL_ADDR, 8'h00);
    rchk(`LCDW_PULL_BASE, 8'h5a);
    wr(`LCDW_SEL_ADDR, `LCDW_ALL_LCD);
  endtask
  task automatic t_mask();
    logic [3:0] nib;
    int n;
    wr(`LCDW_SEG_BASE, 8'hff);
    wr(`LCDW_SEG_LAST, 8'hff);
    for (int m = 0; m < 4; m++) begin
      nib = 4'hf >> (3 - m);
      wr(`LCDW_CTRL_ADDR, m[7:0]);
      wfs(n);
      rchk(`LCDW_SEG_BASE, {nib, nib});
      rchk(`LCDW_SEG_LAST, m == 3 ? 8'h00 : m == 2 ? {4'h0, nib} : {nib, nib});
    end
    wfs(n);
    wr(`LCDW_SEG_BASE, 8'h5a);
    rchk(`LCDW_SEG_BASE, 8'hff);
    wfs(n);
    rchk(`LCDW_SEG_BASE, 8'h5a);
  endtask
  task automatic t_rate();
    logic [7:0] fr [4] = '{8'h00, 8'he1, 8'h22, 8'h63};
    logic [1:0] mx [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(`LCDW_FRAME_ADDR, fr[i]);
      wr(`LCDW_CTRL_ADDR, {6'h0, mx[i]});
      wfs(n);
      wfs(n);
      chk("frame cycles", 64'(2 * (fr[i][7:5] + 1) * (mx[i] + 1) * (64 >> fr[i][1:0])),
        64'(n));
    end
  endtask
  task automatic t_sleep();
    int n;
    wr(`LCDW_FRAME_ADDR, 8'h00);
    wr(`LCDW_CTRL_ADDR, 8'h01);
    wfs(n);
    wfs(n);
    wr(`LCDW_CTRL_ADDR, 8'h05);
    repeat (150) @(posedge mclk);
    chk("active mid frame", 64'h1, {63'h0, active});
    repeat (150) @(posedge mclk);
    chk("active asleep", 64'h0, {63'h0, active});
    // a write while the clock enable is low must not land
    cen <= 1'b0;
    wr(`LCDW_FRAME_ADDR, 8'hff);
    cen <= 1'b1;
    wr(`LCDW_SEG_BASE, 8'h03);
    rchk(`LCDW_CTRL_ADDR, 8'h05);
    rchk(`LCDW_FRAME_ADDR, 8'h00);
    wr(`LCDW_CTRL_ADDR, 8'h01);
    wfs(n);
    chk("wake delay", 64'h1, {63'h0, n < 100});
    rchk(`LCDW_SEG_BASE, 8'h03);
    wr(`LCDW_SEG_BASE, 8'h01);
    wfs(n);
    gclr <= 1'b0;
    wfs(n);
    wfs(n);
    chk("glass lit", 64'h1, {62'h0, lit});
  endtask
  task automatic t_bias();
    int n;
    wr(`LCDW_BIAS_ADDR, 8'h0d);
    outs("off outs", 4'h4);
    wr(`LCDW_BIAS_ADDR, 8'h31);
    outs("third bias outs", 4'h9);
    for (int c = 0; c < 4; c++) begin
      wr(`LCDW_BIAS_ADDR, {2'h0, c[1:0], 4'h5});
      outs("half bias outs", 4'hb);
      n = 0;
      repeat (256) begin
        @(posedge mclk);
        #1 n += pump;
      end
      chk("pump count", 64'(4 << c), 64'(n));
    end
    wr(`LCDW_BIAS_ADDR, 8'h37);
    outs("standby outs", 4'h3);
    n = 0;
    repeat (256) begin
      @(posedge mclk);
      #1 n += pump;
    end
    chk("standby pumps", 64'h0, 64'(n));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_mask();
    t_rate();
    t_sleep();
    t_bias();
    print_verdict();
  end
  // bounds a hang well above the roughly 10000 cycles the run needs
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    print_verdict();
  end
endmodule // lcdw_ctrl_tb_top

/* lcdw_defs.vh */
// Purpose: shared constants of the segment lcd waveform controller
// Assumes: included once per compile unit
// Notes:   register addresses are byte-wide word indices on the plain port
`ifndef LCDW_DEFS_VH
`define LCDW_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define LCDW_ADDR_W        6
`define LCDW_SEG_BASE      6'h00
`define LCDW_SEG_LAST      6'h0f
`define LCDW_SEL_ADDR      6'h10
`define LCDW_CTRL_ADDR     6'h11
`define LCDW_FRAME_ADDR    6'h12
`define LCDW_BIAS_ADDR     6'h13
`define LCDW_PULL_BASE     6'h14
`define LCDW_DIR_BASE      6'h18
`define LCDW_OUT_BASE      6'h1c
`define LCDW_IN_BASE       6'h20
`define LCDW_IN_LAST       6'h23

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define LCDW_CTRL_MUX      1:0
`define LCDW_CTRL_SLEEP    2
`define LCDW_FR_FREQ       1:0
`define LCDW_FR_DIV        7:5
`define LCDW_BG_REF        0
`define LCDW_BG_STDB       1
`define LCDW_BG_MODE       2
`define LCDW_BG_OFF        3
`define LCDW_BG_CLK        5:4
`define LCDW_SEL_RST       8'h00
`define LCDW_CTRL_RST      8'h00
`define LCDW_FRAME_RST     8'h00
`define LCDW_BIAS_RST      8'h28
`define LCDW_ALL_LCD       8'hff

// ----------------------------------------------------------------
// multiplexing codes and drive levels
// ----------------------------------------------------------------
`define LCDW_MUX_DD        2'h0
`define LCDW_MUX_2         2'h1
`define LCDW_MUX_3         2'h2
`define LCDW_MUX_4         2'h3
`define LCDW_V0            2'h0
`define LCDW_V1            2'h1
`define LCDW_V2            2'h2
`define LCDW_V3            2'h3
`define LCDW_LAST_REG      4'hf

`endif

/* lcdw_glass.sv */
// Purpose: passive segment glass seen from pad 0
// Assumes: level codes 0..3 stand for rails V0..V3
// Notes:   a segment darkens only on a full V0 to V3 swing
`timescale 1ns/10ps
module lcdw_glass (
  input  logic       mclk,
  input  logic       clr,
  input  logic [1:0] seg_lvl,
  input  logic [1:0] com0_lvl,
  input  logic [1:0] com1_lvl,
  output logic [1:0] lit
);
  // lit bits stay set until clr; clr starts a fresh look at the glass
  always_ff @(posedge mclk) begin
    if (clr)
      lit <= 2'h0;
    else begin
      if ({seg_lvl, com0_lvl} inside {4'h3, 4'hc}) lit[0] <= 1'b1;
      if ({seg_lvl, com1_lvl} inside {4'h3, 4'hc}) lit[1] <= 1'b1;
    end
  end
endmodule // lcdw_glass
